// ### verilog/scc_char_cfg.svh
`ifndef SCC_CHAR_CFG_SVH
`define SCC_CHAR_CFG_SVH

// register byte offsets
`define OFS_TERM_CHAR  12'h148
`define OFS_IMM_CHAR   12'h14c
`define OFS_SYNC       12'h150
`define OFS_MASK       12'h154
`define OFS_STATUS     12'h158
`define OFS_CONFIG     12'h15c
`define OFS_CHAN_STAT  12'h160

// reset values and bit layout
`define MASK_RESET     32'hffffffff
`define STATUS_RESET   32'hffffffff
`define IRQ_USED       32'hf005f3ff
`define TERM_EN_BIT    15
`define CFG_W          10
`define CFG_HUNT_BIT   10
`define EV_ALL_SENT    18
`define EV_TCD         7
`define EV_SCD         4

// bus answers
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### verilog/scc_char_pkg.sv
package scc_char_pkg;

   typedef enum logic [1:0] {MODE_HDLC, MODE_ASYNC, MODE_BISYNC, MODE_RSVD} mode_t;

   typedef enum logic [1:0] {IMM_IDLE, IMM_OFFER, IMM_SEND} imm_state_t;

   typedef struct packed {
      logic        fill_en;
      logic        sync_len;
      logic        dual;
      logic        hw_flow;
      logic [1:0]  char_len;
      logic        mask_vis;
      logic        auto_m;
      mode_t       mode;
   } cfg_t;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } axi_rsp_t;

   typedef struct packed {
      axi_rsp_t    rsp;
      logic        aw_held;
      logic [11:0] awaddr;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      cfg_t        cfg;
      logic [7:0]  term_char;
      logic        term_en;
      logic [7:0]  imm_char;
      logic [7:0]  sync_lo;
      logic [7:0]  sync_hi;
      logic [31:0] mask;
      logic [31:0] status;
      imm_state_t  imm_state;
      logic        hunt;
      logic [15:0] sync_shift;
      logic        cts_s1;
      logic        cts_s2;
      logic        frame_end;
      logic        sync_found;
      logic [15:0] sync_word;
      logic        imm_valid;
      logic [7:0]  imm_data;
      logic        imm_pending;
      logic        idle_fill;
      logic        irq;
      logic        vec_valid;
      logic [31:0] vec_bits;
   } st_t;

endpackage

// ### verilog/scc_char_and_irq_regs.sv
`timescale 1ns/1ps
`include "scc_char_cfg.svh"
// Functional notes
// RULE1 - compare received chars to term_char when enabled, async and byte-sync only
// RULE2 - a termination match raises a one-cycle frame-end indication
// RULE3 - software clears unused upper term_char bits, else no match occurs
// RULE4 - char_length picks 5 to 8 significant low-order bits
// RULE5 - async write of immediate_tx_char inserts that char into the tx stream
// RULE6 - idle transmitter starts the immediate char at once, then idles
// RULE7 - busy transmitter sends immediate char next, then resumes the FIFO
// RULE8 - immediate char ignores in-band XOFF flow control
// RULE9 - immediate char still waits for clear-to-send when hardware flow chosen
// RULE10 - immediate char framed like normal chars, using configured low bits
// RULE11 - immediate_tx_pending stays set from write until the char is fully sent
// RULE12 - software must not rewrite immediate_tx_char while pending is set
// RULE13 - single sync uses low byte only: 6 or 8 bits by length select
// RULE14 - dual sync concatenates high above low: 12 or 16 bits
// RULE15 - byte-sync idle with fill enabled sends the sync pattern continuously
// RULE16 - hunt mode searches the received bit stream for the sync pattern
// RULE17 - each mask bit gates the status event at the same position
// RULE18 - unmasked event yields an interrupt vector and pin assertion
// RULE19 - masked event yields neither vector nor pin assertion
// RULE20 - masked events recorded in status only when masked_visible is set
// RULE21 - after reset all events are masked, mask reads all ones
// RULE22 - HDLC non-auto: all-sent when last frame bit leaves and FIFO empty
// RULE23 - HDLC auto: all-sent on I-frame acknowledge or acknowledge timeout
// RULE24 - async and byte-sync: all-sent when last char left and FIFO empty
// RULE25 - unused char register bits read zero; unused mask/status bits read one
module scc_char_and_irq_regs
   import scc_char_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire axi_req_t    axi_req,
   output axi_rsp_t         axi_rsp,
   input  wire logic        cts_n_pin,
   input  wire logic        rx_char_valid,
   input  wire logic [7:0]  rx_char,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_bit,
   input  wire logic        tx_imm_take,
   input  wire logic        tx_imm_done,
   input  wire logic        tx_busy,
   input  wire logic        tx_fifo_empty,
   input  wire logic        tx_last_done,
   input  wire logic        ack_ok,
   input  wire logic        ack_timeout,
   input  wire logic [31:0] events_in,
   output logic             frame_end,
   output logic             imm_valid,
   output logic [7:0]       imm_data,
   output logic             immediate_tx_pending,
   output logic             idle_fill,
   output logic [15:0]      sync_word,
   output logic             sync_found,
   output logic             interrupt_out_pin,
   output logic             irq_vec_valid,
   output logic [31:0]      irq_vec_bits
);

   //********************************************************
   // helpers
   //********************************************************
   function automatic logic [7:0] char_mask(input logic [1:0] len);
      return 8'hff >> (2'd3 - len); // RULE4
   endfunction

   function automatic logic [15:0] sync_pat(input cfg_t c, input logic [7:0] hi,
                                            input logic [7:0] lo);
      logic [15:0] p;
      if (c.dual)
         p = c.sync_len ? {hi, lo} : {4'h0, hi[5:0], lo[5:0]}; // RULE14
      else
         p = c.sync_len ? {8'h00, lo} : {10'h000, lo[5:0]}; // RULE13
      return p;
   endfunction

   function automatic logic [15:0] sync_msk(input cfg_t c);
      logic [15:0] m;
      if (c.dual)
         m = c.sync_len ? 16'hffff : 16'h0fff;
      else
         m = c.sync_len ? 16'h00ff : 16'h003f;
      return m;
   endfunction

   function automatic logic [31:0] strb(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      return r;
   endfunction

   function automatic st_t rst_val();
      st_t s;
      s = '0;
      s.rsp.awready = 1'b1;
      s.rsp.wready  = 1'b1;
      s.rsp.arready = 1'b1;
      s.mask        = `MASK_RESET; // RULE21
      s.status      = `STATUS_RESET;
      return s;
   endfunction

   localparam st_t ST_RST = rst_val();

   st_t         st_r;
   st_t         st_nxt;
   logic        is_async;
   logic        is_bsync;
   logic        cts_ok;
   logic        tcd;
   logic        all_sent;
   logic        do_wr;
   logic [15:0] shift_in;
   logic [31:0] ev;
   logic [31:0] wd;
   logic [31:0] rd;
   logic [31:0] clr;
   logic [11:0] ra;
   logic        rhit;
   logic        whit;
   logic [31:0] cfg_w;

   //********************************************************
   // next state
   //********************************************************
   always_comb
   begin
      st_nxt   = st_r;
      is_async = st_r.cfg.mode == MODE_ASYNC;
      is_bsync = st_r.cfg.mode == MODE_BISYNC;
      clr      = 32'h0;
      rd       = 32'h0;
      rhit     = 1'b1;
      whit     = 1'b1;
      cfg_w    = 32'h0;
      wd       = strb(32'h0, st_r.wdata, st_r.wstrb);
      ra       = axi_req.araddr[11:0] & 12'hffc;

      // cts pin crosses two flops before use
      st_nxt.cts_s1 = cts_n_pin;
      st_nxt.cts_s2 = st_r.cts_s1;
      cts_ok = !st_r.cfg.hw_flow || !st_r.cts_s2; // RULE9

      // termination character monitor
      tcd = rx_char_valid && (is_async || is_bsync) && st_r.term_en &&
            ((rx_char & char_mask(st_r.cfg.char_len)) == st_r.term_char); // RULE1 RULE3
      st_nxt.frame_end = tcd; // RULE2

      // sync hunt
      shift_in = {st_r.sync_shift[14:0], rx_bit};
      if (rx_bit_valid)
         st_nxt.sync_shift = shift_in;
      st_nxt.sync_found = st_r.hunt && is_bsync && rx_bit_valid &&
         ((shift_in & sync_msk(st_r.cfg)) ==
          sync_pat(st_r.cfg, st_r.sync_hi, st_r.sync_lo)); // RULE16
      if (st_nxt.sync_found)
         st_nxt.hunt = 1'b0;

      // immediate character sequencing
      case (st_r.imm_state)
         IMM_IDLE:
            st_nxt.imm_state = IMM_IDLE;
         IMM_OFFER:
            if (tx_imm_take && st_r.imm_valid)
               st_nxt.imm_state = IMM_SEND; // RULE6 RULE7
         IMM_SEND:
            if (tx_imm_done)
               st_nxt.imm_state = IMM_IDLE; // RULE11
         default:
            st_nxt.imm_state = IMM_IDLE;
      endcase

      // all-sent event per mode
      if (st_r.cfg.mode == MODE_HDLC && st_r.cfg.auto_m)
         all_sent = ack_ok || ack_timeout; // RULE23
      else
         all_sent = tx_last_done && tx_fifo_empty; // RULE22 RULE24

      // write channel
      if (axi_req.awvalid && st_r.rsp.awready)
      begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr  = axi_req.awaddr[11:0] & 12'hffc;
      end
      if (axi_req.wvalid && st_r.rsp.wready)
      begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata  = axi_req.wdata;
         st_nxt.wstrb  = axi_req.wstrb;
      end
      if (st_r.rsp.bvalid && axi_req.bready)
         st_nxt.rsp.bvalid = 1'b0;
      do_wr = st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid;
      if (do_wr)
      begin
         st_nxt.aw_held    = 1'b0;
         st_nxt.w_held     = 1'b0;
         st_nxt.rsp.bvalid = 1'b1;
         case (st_r.awaddr)
            `OFS_TERM_CHAR:
            begin
               if (st_r.wstrb[0])
                  st_nxt.term_char = st_r.wdata[7:0];
               if (st_r.wstrb[1])
                  st_nxt.term_en = st_r.wdata[`TERM_EN_BIT];
            end
            `OFS_IMM_CHAR:
               if (st_r.wstrb[0] && st_r.imm_state == IMM_IDLE)
               begin
                  st_nxt.imm_char = st_r.wdata[7:0];
                  if (is_async)
                     st_nxt.imm_state = IMM_OFFER; // RULE5
               end
            `OFS_SYNC:
            begin
               if (st_r.wstrb[0])
                  st_nxt.sync_lo = st_r.wdata[7:0];
               if (st_r.wstrb[1])
                  st_nxt.sync_hi = st_r.wdata[15:8];
            end
            `OFS_MASK:
               st_nxt.mask = strb(st_r.mask, st_r.wdata, st_r.wstrb);
            `OFS_CONFIG:
            begin
               cfg_w      = strb({22'h0, st_r.cfg}, st_r.wdata, st_r.wstrb);
               st_nxt.cfg = cfg_t'(cfg_w[`CFG_W-1:0]);
               if (wd[`CFG_HUNT_BIT])
                  st_nxt.hunt = 1'b1;
            end
            `OFS_STATUS, `OFS_CHAN_STAT:
               whit = 1'b1;
            default:
               whit = 1'b0;
         endcase
         st_nxt.rsp.bresp = whit ? `RESP_OKAY : `RESP_SLVERR;
      end
      st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
      st_nxt.rsp.wready  = !st_nxt.w_held && !st_nxt.rsp.bvalid;

      // read channel
      case (ra)
         `OFS_TERM_CHAR:
            rd = {16'h0, st_r.term_en, 7'h0, st_r.term_char}; // RULE25
         `OFS_IMM_CHAR:
            rd = {24'h0, st_r.imm_char};
         `OFS_SYNC:
            rd = {16'h0, st_r.sync_hi, st_r.sync_lo};
         `OFS_MASK:
            rd = st_r.mask | ~`IRQ_USED; // RULE25
         `OFS_STATUS:
            rd = st_r.status | ~`IRQ_USED;
         `OFS_CONFIG:
            rd = {22'h0, st_r.cfg};
         `OFS_CHAN_STAT:
            rd = {30'h0, st_r.hunt, st_r.imm_pending};
         default:
            rhit = 1'b0;
      endcase
      if (st_r.rsp.rvalid && axi_req.rready)
      begin
         st_nxt.rsp.rvalid  = 1'b0;
         st_nxt.rsp.arready = 1'b1;
      end
      if (axi_req.arvalid && st_r.rsp.arready)
      begin
         st_nxt.rsp.rvalid  = 1'b1;
         st_nxt.rsp.arready = 1'b0;
         st_nxt.rsp.rdata   = rd;
         st_nxt.rsp.rresp   = rhit ? `RESP_OKAY : `RESP_SLVERR;
         if (ra == `OFS_STATUS)
            clr = `IRQ_USED;
      end

      // events: set wins over read clear
      ev = events_in;
      ev[`EV_ALL_SENT] = ev[`EV_ALL_SENT] | all_sent;
      ev[`EV_TCD]  = ev[`EV_TCD] | tcd;
      ev[`EV_SCD]  = ev[`EV_SCD] | st_nxt.sync_found;
      ev = ev & `IRQ_USED;
      st_nxt.status = (st_r.status & ~clr) |
         (ev & (~st_r.mask | {32{st_r.cfg.mask_vis}})); // RULE20
      st_nxt.vec_bits  = ev & ~st_r.mask; // RULE17
      st_nxt.vec_valid = |(ev & ~st_r.mask); // RULE18 RULE19
      st_nxt.irq = |(st_nxt.status & ~st_nxt.mask & `IRQ_USED); // RULE18 RULE19

      // transmit-side outputs
      st_nxt.imm_pending = st_nxt.imm_state != IMM_IDLE; // RULE11
      st_nxt.imm_valid = st_nxt.imm_state == IMM_OFFER && cts_ok; // RULE8 RULE9
      st_nxt.imm_data = st_nxt.imm_char & char_mask(st_nxt.cfg.char_len); // RULE10
      st_nxt.idle_fill = is_bsync && st_r.cfg.fill_en && tx_fifo_empty && !tx_busy; // RULE15
      st_nxt.sync_word = sync_pat(st_nxt.cfg, st_nxt.sync_hi, st_nxt.sync_lo);
   end

   //********************************************************
   // state register
   //********************************************************
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         st_r <= ST_RST;
      else if (ce)
         st_r <= st_nxt;
   end

   assign axi_rsp              = st_r.rsp;
   assign frame_end            = st_r.frame_end;
   assign imm_valid            = st_r.imm_valid;
   assign imm_data             = st_r.imm_data;
   assign immediate_tx_pending = st_r.imm_pending;
   assign idle_fill            = st_r.idle_fill;
   assign sync_word            = st_r.sync_word;
   assign sync_found           = st_r.sync_found;
   assign interrupt_out_pin    = st_r.irq;
   assign irq_vec_valid        = st_r.vec_valid;
   assign irq_vec_bits         = st_r.vec_bits;

   //********************************************************
   // checks
   //********************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_term_hit;
      ce && tcd;
   endsequence

   sequence s_imm_write;
      ce && do_wr && st_r.awaddr == `OFS_IMM_CHAR && st_r.wstrb[0] &&
      is_async && st_r.imm_state == IMM_IDLE;
   endsequence

   AST_TERM_DETECT: assert property (s_term_hit |=> frame_end) // RULE2
      else $error("termination match gave no frame end");
   AST_TERM_OFF: assert property (ce && !(st_r.term_en && rx_char_valid) |=> !frame_end) // RULE1
      else $error("frame end without enabled termination match");
   AST_IMM_START: assert property (s_imm_write |=> immediate_tx_pending ##0
                                   (imm_valid || st_r.cfg.hw_flow)) // RULE5
      else $error("immediate write did not start insertion");
   AST_IMM_HOLD: assert property (ce && immediate_tx_pending &&
                                  !(st_r.imm_state == IMM_SEND && tx_imm_done)
                                  |=> immediate_tx_pending) // RULE11
      else $error("pending dropped before completion");
   AST_IMM_CTS: assert property (ce && st_nxt.imm_valid && st_r.cfg.hw_flow
                                 |-> !st_r.cts_s2) // RULE9
      else $error("immediate char offered without clear to send");
   AST_MASK_RESET: assert property ($rose(resetn) |-> st_r.mask == `MASK_RESET) // RULE21
      else $error("mask not all ones after reset");
   AST_IRQ_GATE: assert property (interrupt_out_pin |->
                                  |(st_r.status & ~st_r.mask & `IRQ_USED)) // RULE19
      else $error("interrupt pin with no unmasked event");
   AST_HIDE_MASKED: assert property (ce && !st_r.cfg.mask_vis && events_in[16] &&
                                     st_r.mask[16] && !st_r.status[16] && clr[16] == 1'b0
                                     |=> !st_r.status[16]) // RULE20
      else $error("hidden masked event recorded");
   AST_ALL_SENT: assert property (ce && is_async && tx_last_done && tx_fifo_empty &&
                                  !st_r.mask[`EV_ALL_SENT] |=> st_r.status[`EV_ALL_SENT]
                                  ##0 interrupt_out_pin) // RULE24
      else $error("all sent not flagged");
   AST_SYNC_HUNT: assert property (ce && st_nxt.sync_found |=> sync_found && !st_r.hunt) // RULE16
      else $error("sync detect did not leave hunt");
   AST_AUTO_ALL_SENT: assert property (ce && st_r.cfg.mode == MODE_HDLC && st_r.cfg.auto_m &&
                                       (ack_ok || ack_timeout) &&
                                       (st_r.cfg.mask_vis || !st_r.mask[`EV_ALL_SENT])
                                       |=> st_r.status[`EV_ALL_SENT]) // RULE23
      else $error("auto mode all sent not flagged");
   AST_SYNC_SINGLE: assert property (!st_r.cfg.dual |-> sync_word[15:8] == 8'h00) // RULE13
      else $error("single sync pattern uses high byte");

endmodule

// ### tb/tx_engine_model.sv
`timescale 1ns/1ps
// ********
// stand-in for the transmit engine and serial line
// ********
module tx_engine_model
(
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       imm_valid,
   input  wire logic [3:0] take_delay,
   output logic            tx_imm_take,
   output logic            tx_imm_done,
   output logic            tx_busy,
   output logic            tx_fifo_empty,
   output logic            tx_last_done
);
   int cnt;
   assign tx_fifo_empty = 1'b1;
   initial
   begin
      tx_imm_take = 1'b0;
      tx_imm_done = 1'b0;
      tx_busy = 1'b0;
      tx_last_done = 1'b0;
      cnt = 0;
   end
   always @(posedge core_clk)
   begin
      tx_imm_take <= 1'b0;
      tx_imm_done <= 1'b0;
      tx_last_done <= 1'b0;
      if (!resetn)
      begin
         cnt <= 0;
         tx_busy <= 1'b0;
      end
      else if (tx_busy)
      begin
         cnt <= cnt + 1;
         if (cnt == 10)
         begin
            cnt <= 0;
            tx_busy <= 1'b0;
            tx_imm_done <= 1'b1;
            tx_last_done <= 1'b1;
         end
      end
      else if (imm_valid)
      begin
         cnt <= cnt + 1;
         if (cnt >= int'(take_delay))
         begin
            cnt <= 0;
            tx_imm_take <= 1'b1;
            tx_busy <= 1'b1;
         end
      end
   end
endmodule

// ### tb/test_scc_char_and_irq_regs.sv
`timescale 1ns/1ps
`include "scc_char_cfg.svh"
module test_scc_char_and_irq_regs
   import scc_char_pkg::*;
;
   logic        core_clk, resetn, ce, cts_n_pin, rx_char_valid, rx_bit_valid, rx_bit;
   logic [7:0]  rx_char, imm_data;
   logic [31:0] events_in, irq_vec_bits, d, v, m, vb;
   logic [15:0] sync_word;
   logic [3:0]  take_delay;
   logic [1:0]  r;
   logic        frame_end, imm_valid, immediate_tx_pending, idle_fill, sync_found;
   logic        interrupt_out_pin, irq_vec_valid, fe, sf, vec, pin;
   logic        tx_imm_take, tx_imm_done, tx_busy, tx_fifo_empty, tx_last_done;
   logic        ack_ok, ack_timeout;
   axi_req_t    axi_req;
   axi_rsp_t    axi_rsp;
   int          n_mismatch, n_compared, cyc, k;
   localparam logic [31:0] UNUSED = ~`IRQ_USED;

   scc_char_and_irq_regs dut (.core_clk(core_clk), .resetn(resetn), .ce(ce),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .cts_n_pin(cts_n_pin),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit), .tx_imm_take(tx_imm_take), .tx_imm_done(tx_imm_done),
      .tx_busy(tx_busy), .tx_fifo_empty(tx_fifo_empty), .tx_last_done(tx_last_done),
      .ack_ok(ack_ok), .ack_timeout(ack_timeout), .events_in(events_in),
      .frame_end(frame_end),
      .imm_valid(imm_valid), .imm_data(imm_data),
      .immediate_tx_pending(immediate_tx_pending), .idle_fill(idle_fill),
      .sync_word(sync_word), .sync_found(sync_found),
      .interrupt_out_pin(interrupt_out_pin), .irq_vec_valid(irq_vec_valid),
      .irq_vec_bits(irq_vec_bits));

   tx_engine_model partner (.core_clk(core_clk), .resetn(resetn), .imm_valid(imm_valid),
      .take_delay(take_delay), .tx_imm_take(tx_imm_take), .tx_imm_done(tx_imm_done),
      .tx_busy(tx_busy), .tx_fifo_empty(tx_fifo_empty), .tx_last_done(tx_last_done));

   always #2.5 core_clk = ~core_clk;

   // ********
   // shared tasks
   // ********
   task automatic complete_run;
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] dat);
      @(posedge core_clk);
      axi_req.awaddr <= {20'h0, a};
      axi_req.wdata <= dat;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (axi_req.awvalid && axi_rsp.awready)
            axi_req.awvalid <= 1'b0;
         if (axi_req.wvalid && axi_rsp.wready)
            axi_req.wvalid <= 1'b0;
      end while (!axi_rsp.bvalid);
      r = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge core_clk);
      axi_req.araddr <= {20'h0, a};
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (axi_req.arvalid && axi_rsp.arready)
            axi_req.arvalid <= 1'b0;
      end while (!axi_rsp.rvalid);
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
   endtask

   task automatic watch(input int n);
      fe = 0;
      sf = 0;
      vec = 0;
      pin = 0;
      vb = '0;
      repeat (n)
      begin
         @(posedge core_clk);
         rx_char_valid <= 1'b0;
         rx_bit_valid <= 1'b0;
         events_in <= '0;
         ack_ok <= 1'b0;
         ack_timeout <= 1'b0;
         #1;
         fe |= frame_end;
         sf |= sync_found;
         pin |= interrupt_out_pin;
         if (irq_vec_valid)
         begin
            vec = 1;
            vb |= irq_vec_bits;
         end
      end
   endtask

   task automatic wait_idle;
      for (k = 0; k < 200 && immediate_tx_pending; k++)
         @(posedge core_clk);
      #1;
   endtask

   function automatic logic [31:0] sync_exp(input logic dual, input logic sync_length_select,
                                            input logic [15:0] s);
      if (dual)
         return sync_length_select ? {16'h0, s} : {20'h0, s[13:8], s[5:0]};
      return sync_length_select ? {24'h0, s[7:0]} : {26'h0, s[5:0]};
   endfunction

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   // ********
   // main sequence
   // ********
   initial
   begin
      core_clk = 0; resetn = 0; ce = 1; cts_n_pin = 0; rx_char_valid = 0; rx_char = 0;
      rx_bit_valid = 0; rx_bit = 0; events_in = 0; axi_req = '0; take_delay = 0; cyc = 0;
      n_mismatch = 0; n_compared = 0; ack_ok = 0; ack_timeout = 0;
      void'($urandom(32'h89b8));
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      rd(`OFS_MASK); chk("mask reset", `MASK_RESET, d);
      rd(`OFS_STATUS); chk("status reset", `STATUS_RESET, d);
      rd(`OFS_SYNC); chk("sync reset", 32'h0, d);
      rd(12'h100); chk("unmapped rresp", 32'(`RESP_SLVERR), {30'h0, r});
      wr(12'h104, 32'h1); chk("unmapped bresp", 32'(`RESP_SLVERR), {30'h0, r});
      for (int i = 0; i < 8; i++)
      begin
         d = $urandom;
         wr(`OFS_CONFIG, 32'h2 | (i << 7));
         wr(`OFS_SYNC, d);
         v = d;
         rd(`OFS_SYNC); chk("sync readback", v & 32'hffff, d);
         chk("sync word", sync_exp(i[0], i[1], v[15:0]), {16'h0, sync_word});
         chk("idle fill", {31'h0, i[2]}, {31'h0, idle_fill});
      end
      v = $urandom | 32'h80;
      wr(`OFS_CONFIG, 32'h102);
      wr(`OFS_SYNC, v & 32'hff);
      wr(`OFS_CONFIG, 32'h502);
      for (k = 7; k >= 0; k--)
      begin
         @(posedge core_clk);
         rx_bit_valid <= 1'b1;
         rx_bit <= v[k];
      end
      watch(4); chk("sync found", 32'h1, {31'h0, sf});
      v = $urandom & 32'hff;
      wr(`OFS_TERM_CHAR, 32'h8000 | v);
      for (int i = 0; i < 4; i++)
      begin
         wr(`OFS_CONFIG, 32'h38 | ((i == 3) ? 32'h1 : i));
         @(posedge core_clk);
         rx_char_valid <= 1'b1;
         rx_char <= (i == 3) ? v[7:0] ^ 8'h01 : v[7:0];
         watch(3); chk("frame end", {31'h0, i == 1 || i == 2}, {31'h0, fe});
      end
      m = ($urandom | 32'h2) & ~32'h1;
      v = ($urandom & `IRQ_USED) | 32'h3;
      wr(`OFS_CONFIG, 32'h31);
      wr(`OFS_MASK, m);
      rd(`OFS_MASK); chk("mask readback", m | UNUSED, d);
      rd(`OFS_STATUS);
      @(posedge core_clk);
      events_in <= v;
      watch(3); chk("vector", 32'h1, {31'h0, vec});
      chk("vector bits", v & ~m, vb);
      chk("pin", 32'h1, {31'h0, pin});
      rd(`OFS_STATUS); chk("status hidden", UNUSED | (v & ~m), d);
      v = ($urandom & `IRQ_USED) | 32'h2;
      wr(`OFS_CONFIG, 32'h39);
      @(posedge core_clk);
      events_in <= v;
      watch(3); chk("masked vector", v & ~m, vb);
      rd(`OFS_STATUS); chk("status shown", UNUSED | v, d);
      wr(`OFS_CONFIG, 32'h09);
      take_delay <= 4'hf;
      v = $urandom & 32'hff;
      wr(`OFS_IMM_CHAR, v);
      #1;
      chk("pending", 32'h1, {31'h0, immediate_tx_pending});
      chk("imm offered", 32'h1, {31'h0, imm_valid});
      chk("imm data", v & 32'h1f, {24'h0, imm_data});
      wr(`OFS_IMM_CHAR, ~v & 32'hff);
      #1; chk("imm data kept", v & 32'h1f, {24'h0, imm_data});
      wait_idle(); chk("pending clear", 32'h0, {31'h0, immediate_tx_pending});
      rd(`OFS_IMM_CHAR); chk("imm readback", v, d);
      rd(`OFS_STATUS); chk("all sent", UNUSED | (32'h1 << `EV_ALL_SENT), d);
      wr(`OFS_CONFIG, 32'h79);
      cts_n_pin <= 1'b1;
      take_delay <= 4'h0;
      wr(`OFS_IMM_CHAR, $urandom & 32'hff);
      repeat (4) @(posedge core_clk);
      #1; chk("cts hold", 32'h0, {31'h0, imm_valid});
      @(posedge core_clk);
      cts_n_pin <= 1'b0;
      wait_idle(); chk("cts release", 32'h0, {31'h0, immediate_tx_pending});
      wr(`OFS_CONFIG, 32'h38);
      wr(`OFS_IMM_CHAR, 32'h55);
      #1; chk("hdlc imm", 32'h0, {31'h0, immediate_tx_pending});
      wr(`OFS_CONFIG, 32'h0c);
      for (int j = 0; j < 2; j++)
      begin
         rd(`OFS_STATUS);
         @(posedge core_clk);
         ack_ok <= (j == 0);
         ack_timeout <= (j == 1);
         watch(2);
         rd(`OFS_STATUS); chk("auto all sent", UNUSED | (32'h1 << `EV_ALL_SENT), d);
      end
      complete_run();
   end
endmodule
